// *** include/clksw_defines.vh ***
// Constants for the clock source switcher: register offsets, fields, codes, counts.
// Assumes a 16-bit register port and one system clock at 50 MHz.
//
// Overview of operation
// - Software may move the system clock among six sources, behind a write lock.
// - Primary submode comes from configuration bits; software only picks primary or not.
// - Switching is enabled only when the switch-and-monitor config bit is 0.
// - With switching disabled, next-source is ignored; current-source shows the initial config.
// - With switching disabled, switch-request bit does nothing and reads 0.
// - Equal current and next source on request clears the request and aborts.
// - A valid switch clears the lock status and clock-fail status bits.
// - Start new source; wait start-up timer for crystal, PLL lock for PLL.
// - Once ready, count 10 cycles of the new clock before switching.
// - On completion clear switch-request and copy next-source into current-source.
// - Stop old source, except slow RC with watchdog/monitor, or kept low-power crystal.
// - The processor keeps running throughout the switching sequence.
// - With the monitor enabled, the slow RC runs always except in Sleep.
// - On oscillator failure outside Sleep and the ready wait, raise a trap and fall back to the fast internal RC.
// - If the PLL was in use at failure, the fallback RC uses the PLL.
// - Tuning register: 6-bit field at bits 5:0, upper bits read zero, reset zero.
`ifndef CLKSW_DEFINES_VH
`define CLKSW_DEFINES_VH

// ****************************************
// Register map
// ****************************************
`define CLKSW_ADDR_W 4
`define CLKSW_OFF_CTRL 4'h0
`define CLKSW_OFF_TRIM 4'h1
`define CLKSW_OFF_UNLOCK 4'h2

// ****************************************
// Control register fields
// ****************************************
`define CLKSW_CUR_HI 14
`define CLKSW_CUR_LO 12
`define CLKSW_NXT_HI 10
`define CLKSW_NXT_LO 8
`define CLKSW_LOCK_BIT 5
`define CLKSW_FAIL_BIT 3
`define CLKSW_REQ_BIT 0
`define CLKSW_TRIM_W 6

// ****************************************
// Unlock keys and byte selectors
// ****************************************
`define CLKSW_KEY_HI1 16'h0078
`define CLKSW_KEY_HI2 16'h009A
`define CLKSW_KEY_LO1 16'h0046
`define CLKSW_KEY_LO2 16'h0057

// ****************************************
// Source codes
// ****************************************
`define CLKSW_SRC_FRC 3'h0
`define CLKSW_SRC_INTERNAL_RC_WITH_PLL 3'h1
`define CLKSW_SRC_PRI 3'h2
`define CLKSW_SRC_PRIPLL 3'h3
`define CLKSW_SRC_LPX 3'h4
`define CLKSW_SRC_SRC 3'h5

// ****************************************
// Timing
// ****************************************
`define CLKSW_SETTLE_CYC 4'hA

`endif

// *** rtl/clksw_top.v ***
// Clock source switcher: control/tuning registers, unlock, switch sequencer, fail-safe fallback.
// Assumes oscillator ready, lock, new-clock edge and fail inputs are synchronous to i_mclk.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "clksw_defines.vh"

module clksw_top #(
	parameter SETTLE_CYCLES = 10
) (
	input wire i_mclk, // System clock
	input wire i_rst_b, // Synchronous reset, active low
	input wire [3:0] i_addr, // Register address
	input wire [15:0] i_wdata, // Write data
	input wire i_wr, // Write strobe
	input wire i_rd, // Read strobe
	output reg [15:0] o_rdata, // Read data, cycle after strobe
	input wire i_switch_monitor_cfg, // 0 enables switching and monitor
	input wire [2:0] i_initial_source_cfg, // Source chosen at reset
	input wire [1:0] i_primary_submode_cfg, // Fixed primary submode
	input wire i_watchdog_en, // Watchdog enabled
	input wire i_low_power_xtal_keep, // Keep low-power crystal on
	input wire i_sleep, // Device in Sleep
	input wire [5:0] i_osc_ready, // Per-source ready (timer done or stable)
	input wire i_pll_lock, // PLL lock detect
	input wire i_new_clk_tick, // One pulse per edge of the starting clock
	input wire i_osc_fail, // Oscillator failure detect
	output reg [5:0] o_osc_en, // Per-source enable
	output reg [2:0] o_sys_src, // Selected system source
	output wire [1:0] o_primary_submode, // Primary submode in use
	output reg o_fail_trap, // Clock-failure trap pulse
	output wire o_switch_busy // Switch in progress
);

	// ****************************************
	// States
	// ****************************************
	localparam ST_IDLE = 4'b0001;
	localparam ST_WAIT = 4'b0010;
	localparam ST_COUNT = 4'b0100;
	localparam ST_SWAP = 4'b1000;

	reg [3:0] state;
	reg [2:0] cur_src;
	reg [2:0] nxt_src;
	reg req_bit;
	reg lock_flag;
	reg fail_flag;
	reg [5:0] trim;
	reg [3:0] settle_cnt;
	reg [1:0] unlock_st;
	reg unlock_hi;
	reg unlock_lo;
	reg [2:0] old_src;
	reg init_done;
	reg [5:0] keep_mask;
	wire sw_en;
	wire is_pll;
	wire src_ready;
	wire ctrl_wr;
	wire [15:0] ctrl_view;

	assign sw_en = ~i_switch_monitor_cfg;
	assign o_primary_submode = i_primary_submode_cfg;
	assign o_switch_busy = ~state[0];
	assign is_pll = (nxt_src == `CLKSW_SRC_INTERNAL_RC_WITH_PLL) || (nxt_src == `CLKSW_SRC_PRIPLL);
	assign src_ready = is_pll ? i_pll_lock : i_osc_ready[nxt_src];
	assign ctrl_wr = i_wr && (i_addr == `CLKSW_OFF_CTRL);

	// Control register view; request reads 0 when switching is off
	assign ctrl_view = {1'b0, cur_src, 1'b0, nxt_src, 2'h0, lock_flag, 1'b0, fail_flag, 2'h0,
		req_bit & sw_en};

	// ****************************************
	// Unlock sequence: two key writes arm one byte
	// ****************************************
	// The arm holds through idle cycles until the next access, so any other access in
	// between drops it and the next control write is ignored.
	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			unlock_st <= 2'h0;
			unlock_hi <= 1'b0;
			unlock_lo <= 1'b0;
		end else begin
			unlock_hi <= 1'b0;
			unlock_lo <= 1'b0;
			unlock_st <= 2'h0;
			if (i_wr && i_addr == `CLKSW_OFF_UNLOCK) begin
				if (i_wdata == `CLKSW_KEY_HI1)
					unlock_st <= 2'h1;
				else if (i_wdata == `CLKSW_KEY_LO1)
					unlock_st <= 2'h2;
				else if (i_wdata == `CLKSW_KEY_HI2 && unlock_st == 2'h1)
					unlock_hi <= 1'b1;
				else if (i_wdata == `CLKSW_KEY_LO2 && unlock_st == 2'h2)
					unlock_lo <= 1'b1;
			end else if (!(i_wr || i_rd)) begin
				unlock_st <= unlock_st;
				unlock_hi <= unlock_hi;
				unlock_lo <= unlock_lo;
			end
		end
	end

	// ****************************************
	// Switch sequencer and status
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			state <= ST_IDLE;
			cur_src <= 3'h0;
			nxt_src <= 3'h0;
			req_bit <= 1'b0;
			lock_flag <= 1'b0;
			fail_flag <= 1'b0;
			settle_cnt <= 4'h0;
			old_src <= 3'h0;
			o_fail_trap <= 1'b0;
			init_done <= 1'b0;
		end else begin
			o_fail_trap <= 1'b0;
			lock_flag <= i_pll_lock;
			if (!init_done || !sw_en) begin
				// Strap taken after release; follows the config while switching is off
				init_done <= 1'b1;
				cur_src <= i_initial_source_cfg;
				if (!init_done)
					nxt_src <= i_initial_source_cfg;
				req_bit <= 1'b0;
				state <= ST_IDLE;
			end else if (i_osc_fail && !i_sleep && state != ST_WAIT) begin
				// Fallback keeps the PLL if it was in use
				o_fail_trap <= 1'b1;
				fail_flag <= 1'b1;
				old_src <= cur_src;
				if (cur_src == `CLKSW_SRC_PRIPLL || cur_src == `CLKSW_SRC_INTERNAL_RC_WITH_PLL)
					cur_src <= `CLKSW_SRC_INTERNAL_RC_WITH_PLL;
				else
					cur_src <= `CLKSW_SRC_FRC;
				req_bit <= 1'b0;
				state <= ST_IDLE;
			end else begin
				if (ctrl_wr && unlock_hi)
					nxt_src <= i_wdata[`CLKSW_NXT_HI:`CLKSW_NXT_LO];
				case (state)
					ST_IDLE: begin
						if (ctrl_wr && unlock_lo && i_wdata[`CLKSW_REQ_BIT])
							req_bit <= 1'b1;
						if (req_bit) begin
							if (cur_src == nxt_src) begin
								req_bit <= 1'b0;
							end else begin
								lock_flag <= 1'b0;
								fail_flag <= 1'b0;
								state <= ST_WAIT;
							end
						end
					end
					ST_WAIT: begin
						settle_cnt <= 4'h0;
						if (src_ready)
							state <= ST_COUNT;
					end
					ST_COUNT: begin
						if (i_new_clk_tick) begin
							if (settle_cnt == SETTLE_CYCLES[3:0] - 4'h1)
								state <= ST_SWAP;
							settle_cnt <= settle_cnt + 4'h1;
						end
					end
					ST_SWAP: begin
						old_src <= cur_src;
						cur_src <= nxt_src;
						req_bit <= 1'b0;
						state <= ST_IDLE;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Oscillator enables and system source
	// ****************************************
	// Slow RC stays on for watchdog or monitor; kept crystal honours its bit.
	always @* begin
		keep_mask = 6'h00;
		if (i_watchdog_en || sw_en)
			keep_mask[`CLKSW_SRC_SRC] = 1'b1;
		if (i_low_power_xtal_keep)
			keep_mask[`CLKSW_SRC_LPX] = 1'b1;
	end

	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_osc_en <= 6'h00;
			o_sys_src <= 3'h0;
		end else begin
			o_sys_src <= cur_src;
			if (i_sleep) begin
				o_osc_en <= 6'h00;
			end else begin
				// Only current, pending and kept sources run; the old one drops here
				o_osc_en <= keep_mask;
				o_osc_en[cur_src] <= 1'b1;
				if (!state[0])
					o_osc_en[nxt_src] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			trim <= 6'h00;
			o_rdata <= 16'h0000;
		end else begin
			if (i_wr && i_addr == `CLKSW_OFF_TRIM)
				trim <= i_wdata[`CLKSW_TRIM_W-1:0];
			o_rdata <= 16'h0000;
			if (i_rd) begin
				if (i_addr == `CLKSW_OFF_CTRL)
					o_rdata <= ctrl_view;
				else if (i_addr == `CLKSW_OFF_TRIM)
					o_rdata <= {10'h000, trim};
			end
		end
	end

endmodule // clksw_top
`default_nettype wire

// *** sim/clksw_props.sv ***
// Port-level checks for the clock switcher.
// Assumes one clock domain and strap inputs that only change during reset.
`timescale 1ns/1ps
`default_nettype none
module clksw_props #(
	parameter int SETTLE_CYCLES = 10
) (
	input wire logic i_mclk, // Clock
	input wire logic i_rst_b, // Reset, low
	input wire logic [3:0] i_addr, // Address
	input wire logic i_rd, // Read strobe
	input wire logic [15:0] o_rdata, // Read data
	input wire logic i_switch_monitor_cfg, // High disables
	input wire logic [1:0] i_primary_submode_cfg, // Submode strap
	input wire logic [1:0] o_primary_submode, // Submode used
	input wire logic i_sleep, // Sleep
	input wire logic i_new_clk_tick, // New-clock edge
	input wire logic [5:0] o_osc_en, // Enables
	input wire logic [2:0] o_sys_src, // Source
	input wire logic o_fail_trap, // Trap
	input wire logic o_switch_busy // Busy
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// ****************************************
	// New-clock edges seen in the current switch
	// ****************************************
	int ticks;
	always_ff @(posedge i_mclk) begin
		if ($rose(o_switch_busy))
			ticks <= 0;
		else if (o_switch_busy)
			ticks <= ticks + int'(i_new_clk_tick);
	end
	sequence trap_once_s;
		o_fail_trap ##1 !o_fail_trap;
	endsequence
	trap_pulse_a: assert property (o_fail_trap |-> trap_once_s)
		else $error("trap not one cycle");
	trap_fallback_a: assert property (o_fail_trap |-> ##[0:2] (o_sys_src inside {3'h0, 3'h1}))
		else $error("no fallback to fast rc");
	submode_fixed_a: assert property (o_primary_submode == i_primary_submode_cfg)
		else $error("submode differs from strap");
	disabled_idle_a: assert property (i_switch_monitor_cfg |-> !o_switch_busy && !o_fail_trap)
		else $error("activity while disabled");
	req_reads_zero_a: assert property (i_switch_monitor_cfg && i_rd && i_addr == 4'h0 |=> !o_rdata[0])
		else $error("request bit set while disabled");
	trim_upper_a: assert property (i_rd && i_addr == 4'h1 |=> o_rdata[15:6] == 10'h000)
		else $error("trim upper bits set");
	settle_count_a: assert property ($changed(o_sys_src) && $past(o_switch_busy, 2) |-> ticks >= SETTLE_CYCLES)
		else $error("switched before settle count");
	slow_rc_on_a: assert property (!i_switch_monitor_cfg && !i_sleep && $past(i_rst_b, 2) |-> o_osc_en[5])
		else $error("slow rc stopped");
endmodule // clksw_props
bind clksw_top clksw_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_switch_monitor_cfg(i_switch_monitor_cfg),
	.i_primary_submode_cfg(i_primary_submode_cfg), .o_primary_submode(o_primary_submode), .i_sleep(i_sleep),
	.i_new_clk_tick(i_new_clk_tick), .o_osc_en(o_osc_en), .o_sys_src(o_sys_src), .o_fail_trap(o_fail_trap),
	.o_switch_busy(o_switch_busy));
`default_nettype wire

// *** sim/clksw_osc_model.sv ***
// Behavioural oscillator bank answering the switcher's enables.
// Assumes registered enables on i_mclk; start-up and lock take 15 cycles.
`timescale 1ns/1ps
`default_nettype none
module clksw_osc_model (
	input wire logic i_mclk, // Clock
	input wire logic [5:0] i_osc_en, // Enables
	output logic [5:0] o_ready, // Started
	output logic o_lock, // PLL locked
	output logic o_tick // New-clock edge
);
	logic ph = 1'b0;
	for (genvar k = 0; k < 6; k++) begin : g_src
		logic [3:0] age = 4'h0;
		always_ff @(posedge i_mclk) age <= !i_osc_en[k] ? 4'h0 : age + {3'h0, age != 4'hF};
		assign o_ready[k] = age == 4'hF;
	end
	always_ff @(posedge i_mclk) ph <= ~ph;
	// Stopped sources give no edges, so ticks wait for a started one
	assign o_tick = ph & |o_ready;
	assign o_lock = o_ready[1] | o_ready[3];
endmodule // clksw_osc_model
`default_nettype wire

// *** sim/clksw_bench.sv ***
// Self-checking bench for the clock switcher and its oscillator model.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "clksw_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %0t %h/%h", $time, g, e); end end
module clksw_bench;
	logic i_mclk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_cfg = 1'b1, i_fail = 1'b0, lock, tick, trap, busy;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000, o_rdata, v;
	logic [2:0] i_init = 3'h2, src;
	logic [5:0] rdy, en;
	logic [1:0] sub;
	int failures = 0, num_checks = 0, cyc = 0;
	clksw_top dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_switch_monitor_cfg(i_cfg), .i_initial_source_cfg(i_init), .i_primary_submode_cfg(2'h1),
		.i_watchdog_en(1'b0), .i_low_power_xtal_keep(1'b0), .i_sleep(1'b0), .i_osc_ready(rdy), .i_pll_lock(lock),
		.i_new_clk_tick(tick), .i_osc_fail(i_fail), .o_osc_en(en), .o_sys_src(src), .o_primary_submode(sub),
		.o_fail_trap(trap), .o_switch_busy(busy));
	clksw_osc_model osc (.i_mclk(i_mclk), .i_osc_en(en), .o_ready(rdy), .o_lock(lock), .o_tick(tick));
	initial begin
		forever #10 i_mclk = ~i_mclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			end_sim();
		end
	end
	task automatic op(input logic w, r, input logic [3:0] a, input logic [15:0] d);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] q);
		op(1'b0, 1'b1, a, 16'h0000);
		// Read data stand only in the cycle after the strobe
		i_rd <= 1'b0;
		@(negedge i_mclk);
		q = o_rdata;
		@(posedge i_mclk);
	endtask
	task automatic ctl(input logic [15:0] k1, k2, d);
		op(1'b1, 1'b0, `CLKSW_OFF_UNLOCK, k1);
		op(1'b1, 1'b0, `CLKSW_OFF_UNLOCK, k2);
		op(1'b1, 1'b0, `CLKSW_OFF_CTRL, d);
		op(1'b0, 1'b0, `CLKSW_OFF_CTRL, 16'h0000);
	endtask
	task automatic rst(input logic c, input logic [2:0] s);
		i_rst_b <= 1'b0;
		i_cfg <= c;
		i_init <= s;
		repeat (4) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_mclk);
	endtask
	task automatic sw(input logic [2:0] n);
		int t;
		t = 0;
		ctl(`CLKSW_KEY_HI1, `CLKSW_KEY_HI2, {5'h00, n, 8'h00});
		ctl(`CLKSW_KEY_LO1, `CLKSW_KEY_LO2, 16'h0001);
		repeat (3) @(posedge i_mclk);
		while (busy !== 1'b0 && t < 300) begin
			@(negedge i_mclk);
			t++;
		end
		repeat (2) @(posedge i_mclk);
		rd(`CLKSW_OFF_CTRL, v);
		`CHK(v[14:12], n)
		`CHK(v[0], 1'b0)
		`CHK(src, n)
	endtask
	task automatic t_disabled();
		sw(3'h2);
		ctl(`CLKSW_KEY_HI1, `CLKSW_KEY_HI2, 16'h0000);
		ctl(`CLKSW_KEY_LO1, `CLKSW_KEY_LO2, 16'h0001);
		rd(`CLKSW_OFF_CTRL, v);
		`CHK(v[0], 1'b0)
		`CHK(src, 3'h2)
	endtask
	task automatic t_trim();
		rd(`CLKSW_OFF_TRIM, v);
		`CHK(v, 16'h0000)
		op(1'b1, 1'b0, `CLKSW_OFF_TRIM, 16'hFFFF);
		rd(`CLKSW_OFF_TRIM, v);
		`CHK(v, 16'h003F)
		rd(4'hF, v);
		`CHK(v, 16'h0000)
	endtask
	task automatic t_unlock();
		op(1'b1, 1'b0, `CLKSW_OFF_CTRL, 16'h0201);
		rd(`CLKSW_OFF_CTRL, v);
		`CHK(v[10:8], 3'h0)
		`CHK(v[0], 1'b0)
		sw(3'h0);
	endtask
	task automatic t_switch_fail();
		sw(3'h2);
		`CHK(en[0], 1'b0)
		sw(3'h3);
		i_fail <= 1'b1;
		@(posedge i_mclk);
		i_fail <= 1'b0;
		repeat (4) @(posedge i_mclk);
		`CHK(src, 3'h1)
		rd(`CLKSW_OFF_CTRL, v);
		`CHK(v[3], 1'b1)
		sw(3'h0);
		`CHK(v[3], 1'b0)
	endtask
	initial begin
		@(posedge i_mclk);
		rst(1'b1, 3'h2);
		t_disabled();
		t_trim();
		rst(1'b0, 3'h0);
		t_unlock();
		t_switch_fail();
		end_sim();
	end
endmodule // clksw_bench
`default_nettype wire
